// File: core/pdx_pkg.sv
// Purpose : shared constants and types of the power-down entry and exit controller
// Assumes : 100 MHz pclk, registers reached over APB with 32-bit data
// Notes   : register offset is an index; the byte address is four times the index
package pdx_pkg;

    // clock rate and the times that become cycle counts
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_STABLE_NS = 2000;   // least time, rounds up
    localparam int RST_WINDOW_NS = 40;     // longest time, rounds down
    localparam int RST_SEQ_NS    = 240;    // least time, rounds up
    localparam logic [7:0] OSC_STABLE_CYC =
        8'((OSC_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RST_WINDOW_CYC =
        8'((RST_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (RST_WINDOW_NS / CLK_PERIOD_NS));
    localparam logic [7:0] RST_SEQ_CYC =
        8'((RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // register map
    localparam logic [7:0]  PWR_CTRL_IDX  = 8'h87;
    localparam logic [11:0] PWR_CTRL_ADDR = {2'h0, PWR_CTRL_IDX, 2'h0};

    // power control field positions
    localparam int IDLE_POS      = 0;
    localparam int PWR_DOWN_POS  = 1;
    localparam int GEN_FLAG0_POS = 2;
    localparam int GEN_FLAG1_POS = 3;
    localparam int PWR_OFF_POS   = 4;
    localparam int RSVD_POS      = 5;
    localparam int FRAME_SEL_POS = 6;
    localparam int BAUD_DBL_POS  = 7;
    localparam logic [7:0] PWR_CTRL_WMASK = 8'hCF;  // bits 5 and 4 not written as data
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;  // value of every field but power-off after any reset sequence
    localparam logic       PWR_OFF_RESET  = 1'b1;   // set only by power-on reset

    // restart vector after a reset wake
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // controller states, one-hot
    typedef enum logic [6:0] {
        ST_RUN     = 7'b000_0001,
        ST_PDOWN   = 7'b000_0010,
        ST_OSCWAIT = 7'b000_0100,
        ST_HOLD    = 7'b000_1000,
        ST_ISR     = 7'b001_0000,
        ST_RSTRUN  = 7'b010_0000,
        ST_RSTSEQ  = 7'b100_0000
    } pdx_state_e;

    // level controls toward the core and clock tree
    typedef struct packed {
        logic osc_en;
        logic core_clk_en;
        logic periph_clk_en;
        logic exec_hold;
        logic ram_block;
    } pdx_core_s;

endpackage

// File: core/pdx_delay.sv
// Purpose : down counter that times oscillator settling and reset phases
// Assumes : start is a one-cycle request taken while ce is high
// Notes   : done pulses for one enabled cycle when the count runs out
`timescale 1ns/1ps
module pdx_delay
    import pdx_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // control
    input  wire logic       start,
    input  wire logic [7:0] load,
    // status
    output logic            done
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_done;

    // load on start, otherwise count down to zero
    always_comb begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (start) begin
            next_cnt = load;
        end else if (cnt != 8'h00) begin
            next_cnt  = cnt - 8'h01;
            next_done = (cnt == 8'h01);
        end
    end

    // register the count, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 8'h00;
            done <= 1'b0;
        end else if (ce) begin
            cnt  <= next_cnt;
            done <= next_done;
        end
    end

endmodule

// File: core/pdx_ctrl.sv
// Purpose : power-down entry and exit controller with its power control register
// Assumes : pins synchronous to pclk; core reports the end of the wake service routine
// Notes   : the reset pin clears the power-down bit without any clock edge
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// (RL1) setting the power-down bit halts the core after the writing instruction
// (RL2) of the interrupts, only wake interrupts 0 and 1 may wake the part from power-down
// (RL3) interrupt wake clears the power-down bit and restarts oscillator and clocks
// (RL4) execution stays held until the waking interrupt input is released
// (RL5) after interrupt wake run the service routine, then resume the next instruction
// (RL6) the waking interrupt is level sensitive and of highest priority
// (RL7) the source holds the interrupt until the oscillator has settled
// (RL8) interrupt wake leaves all registers and internal RAM unchanged
// (RL9) reset pin high clears the power-down bit at once, with no clock
// (RL10) after reset wake the core may run briefly before the reset sequence
// (RL11) at the end of the reset sequence fetching restarts at address zero
// (RL12) during that brief window internal RAM is blocked, port pins are not
// (RL13) software avoids port or external RAM writes right after power-down entry
// (RL14) reset wake restores register reset values but keeps internal RAM
// (RL15) while power-down is set oscillator and all clocks stay stopped
module pdx_ctrl
    import pdx_pkg::*;
(
    // clock, reset and enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // wake sources
    input  wire logic        reset_pin,
    input  wire logic        wake_interrupt_0_n,
    input  wire logic        wake_interrupt_1_n,
    // core side
    input  wire logic        isr_return,
    output pdx_core_s        core_ctl,
    output logic             isr_request,
    output logic [1:0]       isr_source,
    output logic             resume_next,
    output logic             sfr_init,
    output logic             vector_load,
    output logic [15:0]      fetch_addr,
    output logic             power_down_bit
);

    pdx_state_e state;
    pdx_state_e next_state;
    logic [7:0] ctrl_rest;          // all fields except the power-down bit
    logic [7:0] next_ctrl_rest;
    logic       next_pwr_down;
    logic [1:0] wake_src;
    logic [1:0] next_wake_src;
    logic       next_isr_request;
    logic       next_resume_next;
    logic       next_sfr_init;
    logic       next_vector_load;
    logic [31:0] next_prdata;
    logic       next_pslverr;
    logic       tmr_start;
    logic [7:0] tmr_load;
    logic       tmr_done;
    logic       pwr_down_clr_n;
    logic       wake_any;
    logic       wr_ctrl;
    logic       hit;

    // true when an access addresses the power control register
    function automatic logic is_pwr_ctrl(input logic [11:0] addr);
        return addr == PWR_CTRL_ADDR;
    endfunction

    // (RL2) wake sources
    assign wake_any = !wake_interrupt_0_n || !wake_interrupt_1_n;
    assign hit      = is_pwr_ctrl(paddr);
    assign wr_ctrl  = psel && penable && pwrite && hit && clk_en;
    // (RL9) async clear path
    assign pwr_down_clr_n = presetn && !reset_pin;
    assign pready   = clk_en;

    // shared timer for oscillator settling and reset phases
    pdx_delay u_delay (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (clk_en),
        .start   (tmr_start),
        .load    (tmr_load),
        .done    (tmr_done)
    );

    // controller next state and core strobes
    always_comb begin
        next_state       = state;
        next_wake_src    = wake_src;
        next_isr_request = 1'b0;
        next_resume_next = 1'b0;
        next_sfr_init    = 1'b0;
        next_vector_load = 1'b0;
        tmr_start        = 1'b0;
        tmr_load         = OSC_STABLE_CYC;
        case (state)
            ST_RUN: begin
                if (reset_pin) begin
                    next_state = ST_RSTSEQ;
                    tmr_start  = 1'b1;
                    tmr_load   = RST_SEQ_CYC;
                // (RL1) enter power-down
                end else if (power_down_bit) begin
                    next_state = ST_PDOWN;
                end
            end
            ST_PDOWN: begin
                // (RL10) reset wake window
                if (reset_pin) begin
                    next_state = ST_RSTRUN;
                    tmr_start  = 1'b1;
                    // state leaves one cycle after done, so load one less
                    tmr_load   = RST_WINDOW_CYC - 8'h01;
                // (RL3) interrupt wake restart
                end else if (wake_any) begin
                    next_state    = ST_OSCWAIT;
                    next_wake_src = {!wake_interrupt_1_n, !wake_interrupt_0_n};
                    tmr_start     = 1'b1;
                end
            end
            ST_OSCWAIT: begin
                if (reset_pin) begin
                    next_state = ST_RSTSEQ;
                    tmr_start  = 1'b1;
                    tmr_load   = RST_SEQ_CYC;
                end else if (tmr_done) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (reset_pin) begin
                    next_state = ST_RSTSEQ;
                    tmr_start  = 1'b1;
                    tmr_load   = RST_SEQ_CYC;
                // (RL4) resume on release
                end else if (!wake_any) begin
                    next_state       = ST_ISR;
                    next_isr_request = 1'b1;
                end
            end
            ST_ISR: begin
                if (reset_pin) begin
                    next_state = ST_RSTSEQ;
                    tmr_start  = 1'b1;
                    tmr_load   = RST_SEQ_CYC;
                // (RL5) back to next instruction
                end else if (isr_return) begin
                    next_state       = ST_RUN;
                    next_resume_next = 1'b1;
                end
            end
            ST_RSTRUN: begin
                if (tmr_done) begin
                    next_state = ST_RSTSEQ;
                    tmr_start  = 1'b1;
                    tmr_load   = RST_SEQ_CYC;
                end
            end
            ST_RSTSEQ: begin
                // the sequence restarts while the pin stays high
                if (reset_pin) begin
                    tmr_start = 1'b1;
                    tmr_load  = RST_SEQ_CYC;
                // (RL11) restart at the vector
                end else if (tmr_done) begin
                    next_state       = ST_RUN;
                    next_sfr_init    = 1'b1;
                    next_vector_load = 1'b1;
                    next_wake_src    = 2'h0;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // controller registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_RUN;
            wake_src    <= 2'h0;
            isr_request <= 1'b0;
            resume_next <= 1'b0;
            sfr_init    <= 1'b0;
            vector_load <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            wake_src    <= next_wake_src;
            isr_request <= next_isr_request;
            resume_next <= next_resume_next;
            sfr_init    <= next_sfr_init;
            vector_load <= next_vector_load;
        end
    end

    // (RL15) clocks stopped while down
    // (RL12) ram blocked in the reset window
    always_comb begin
        core_ctl.osc_en        = (state != ST_PDOWN);
        core_ctl.core_clk_en   = !(state inside {ST_PDOWN, ST_OSCWAIT});
        core_ctl.periph_clk_en = !(state inside {ST_PDOWN, ST_OSCWAIT});
        core_ctl.exec_hold     = state inside {ST_PDOWN, ST_OSCWAIT, ST_HOLD, ST_RSTSEQ};
        core_ctl.ram_block     = (state == ST_RSTRUN);
    end
    assign isr_source = wake_src;
    assign fetch_addr = RESET_VECTOR;

    // power-down bit next value
    always_comb begin
        next_pwr_down = power_down_bit;
        if (wr_ctrl) begin
            next_pwr_down = pwdata[PWR_DOWN_POS];
        end
        // (RL3) hardware clear on wake
        if (state == ST_PDOWN && wake_any) begin
            next_pwr_down = 1'b0;
        end
        if (sfr_init) begin
            next_pwr_down = 1'b0;
        end
    end

    // (RL9) power-down bit, cleared by the reset pin without a clock
    always_ff @(posedge pclk or negedge pwr_down_clr_n) begin
        if (!pwr_down_clr_n) begin
            power_down_bit <= 1'b0;
        end else if (clk_en) begin
            power_down_bit <= next_pwr_down;
        end
    end

    // other power control fields, changed only by software or a reset sequence
    // (RL8) kept across wake
    always_comb begin
        next_ctrl_rest = ctrl_rest;
        if (wr_ctrl) begin
            next_ctrl_rest = (pwdata[7:0] & PWR_CTRL_WMASK) | (ctrl_rest & ~PWR_CTRL_WMASK);
            // power-off flag is cleared by writing zero, never set by software
            next_ctrl_rest[PWR_OFF_POS] = ctrl_rest[PWR_OFF_POS] & pwdata[PWR_OFF_POS];
        end
        // (RL14) register defaults restored
        if (sfr_init) begin
            next_ctrl_rest              = PWR_CTRL_RESET;
            next_ctrl_rest[PWR_OFF_POS] = ctrl_rest[PWR_OFF_POS];
        end
        next_ctrl_rest[PWR_DOWN_POS] = 1'b0;
        next_ctrl_rest[RSVD_POS]     = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_rest              <= PWR_CTRL_RESET;
            ctrl_rest[PWR_OFF_POS] <= PWR_OFF_RESET;
        end else if (clk_en) begin
            ctrl_rest <= next_ctrl_rest;
        end
    end

    // apb read data and error, captured in the setup cycle
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = !hit;
            if (hit && !pwrite) begin
                next_prdata[7:0] = ctrl_rest | ({7'h00, power_down_bit} << PWR_DOWN_POS);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);

    chk_pd_entry: assert property ( // RL1
        state == ST_RUN && power_down_bit && !reset_pin |=> state == ST_PDOWN)
        else $error("power-down bit set but controller did not halt");

    chk_wake_only: assert property ( // RL2
        state == ST_PDOWN && !wake_any && !reset_pin |=> state == ST_PDOWN)
        else $error("left power-down without a wake source");

    chk_hw_clear: assert property ( // RL3
        state == ST_PDOWN && wake_any && !reset_pin
        |=> !power_down_bit && core_ctl.osc_en && state == ST_OSCWAIT)
        else $error("interrupt wake did not clear power-down and restart oscillator");

    chk_hold_release: assert property ( // RL4
        state == ST_HOLD && wake_any && !reset_pin |=> state == ST_HOLD && core_ctl.exec_hold)
        else $error("execution resumed while wake interrupt still asserted");

    chk_isr_first: assert property ( // RL5
        $rose(resume_next) |-> $past(state == ST_ISR))
        else $error("resume without service routine");

    chk_isr_req: assert property ( // RL5
        state == ST_HOLD && !wake_any && !reset_pin |=> isr_request ##1 !isr_request)
        else $error("service request not a single pulse on release");

    chk_no_sfr_init: assert property ( // RL8
        state == ST_ISR |-> !sfr_init && !core_ctl.ram_block)
        else $error("interrupt wake disturbed registers");

    chk_rst_clear: assert property ( // RL9
        disable iff (!presetn) reset_pin |-> !power_down_bit)
        else $error("reset pin did not clear power-down bit");

    chk_rst_window: assert property ( // RL10
        state == ST_PDOWN && reset_pin |=> state == ST_RSTRUN [*4] ##1 state == ST_RSTSEQ)
        else $error("reset wake window has wrong length");

    chk_vector: assert property ( // RL11
        vector_load |-> fetch_addr == RESET_VECTOR && $past(state == ST_RSTSEQ))
        else $error("restart not from reset sequence at vector zero");

    chk_ram_block: assert property ( // RL12
        core_ctl.ram_block |-> state == ST_RSTRUN && core_ctl.core_clk_en)
        else $error("ram blocked outside the reset window");

    chk_sfr_default: assert property ( // RL14
        sfr_init |=> ctrl_rest[BAUD_DBL_POS] == 1'b0 && ctrl_rest[IDLE_POS] == 1'b0)
        else $error("register defaults not restored by reset wake");

    chk_clk_stop: assert property ( // RL15
        state == ST_PDOWN |-> !core_ctl.osc_en && !core_ctl.core_clk_en
                              && !core_ctl.periph_clk_en)
        else $error("clock running during power-down");

endmodule

// File: tb/pdx_partner.sv
// Purpose : model of the wake interrupt sources and the reset circuit
// Assumes : called from the bench at rising pclk edges
// Notes   : wake lines idle high, reset pin idles low
`timescale 1ns/1ps
module pdx_partner
    import pdx_pkg::*;
(
    // clock
    input  wire logic pclk,
    // pins toward the device
    output logic      reset_pin,
    output logic      wake_interrupt_0_n,
    output logic      wake_interrupt_1_n
);
    // idle levels from time zero
    initial begin
        reset_pin = 1'b0;
        wake_interrupt_0_n = 1'b1;
        wake_interrupt_1_n = 1'b1;
    end

    // pull one wake line low and hold it as a level
    task automatic drive_wake(input int src, input int hold);
        int n;
        n = (hold < int'(OSC_STABLE_CYC) + 8) ? int'(OSC_STABLE_CYC) + 8 : hold;
        @(posedge pclk);
        if (src == 0) wake_interrupt_0_n <= 1'b0;
        else wake_interrupt_1_n <= 1'b0;
        repeat (n) @(posedge pclk);
        wake_interrupt_0_n <= 1'b1;
        wake_interrupt_1_n <= 1'b1;
    endtask

    // raise the reset pin for a number of cycles
    task automatic drive_reset(input int hold);
        @(posedge pclk);
        reset_pin <= 1'b1;
        repeat (hold) @(posedge pclk);
        reset_pin <= 1'b0;
    endtask
endmodule

// File: tb/pdx_ctrl_tb.sv
// Purpose : self-checking bench for the power-down entry and exit controller
// Assumes : apb slave answers when clk_en is high; partner drives wake pins
// Notes   : full settle and reset counts are used, the run stays short
`timescale 1ns/1ps
module pdx_ctrl_tb
    import pdx_pkg::*;
;
    // clock, reset and apb
    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    // wake pins and core side
    logic        reset_pin;
    logic        wake_interrupt_0_n;
    logic        wake_interrupt_1_n;
    logic        isr_return;
    pdx_core_s   core_ctl;
    logic        isr_request;
    logic [1:0]  isr_source;
    logic        resume_next;
    logic        sfr_init;
    logic        vector_load;
    logic [15:0] fetch_addr;
    logic        power_down_bit;
    // bookkeeping
    int          err_count;
    int          n_tests;
    int          cycles;
    logic [31:0] rdata;
    logic        rerr;

    // device under test
    pdx_ctrl dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reset_pin(reset_pin), .wake_interrupt_0_n(wake_interrupt_0_n),
        .wake_interrupt_1_n(wake_interrupt_1_n), .isr_return(isr_return),
        .core_ctl(core_ctl), .isr_request(isr_request), .isr_source(isr_source),
        .resume_next(resume_next), .sfr_init(sfr_init), .vector_load(vector_load),
        .fetch_addr(fetch_addr), .power_down_bit(power_down_bit)
    );

    // wake sources and reset circuit
    pdx_partner partner_u (
        .pclk(pclk), .reset_pin(reset_pin),
        .wake_interrupt_0_n(wake_interrupt_0_n), .wake_interrupt_1_n(wake_interrupt_1_n)
    );

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("BAD t=%0t run did not finish", $time);
            final_report();
        end
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only pready high or the hang guard ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read and compare data and error flag
    task automatic read_expect(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, exp, "read data");
        check({31'h0, rerr}, {31'h0, eerr}, "slave error");
    endtask

    // select a pulse output to wait for
    function automatic logic pick(input int sel);
        case (sel)
            0: return isr_request;
            1: return resume_next;
            default: return vector_load;
        endcase
    endfunction

    // bounded wait for a pulse, sampled after each edge settles
    task automatic wait_hi(input int sel);
        int k;
        k = 0;
        #1;
        while (pick(sel) !== 1'b1 && k < 60) begin
            @(posedge pclk);
            #1;
            k++;
        end
    endtask

    // counts and verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        int s;
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        isr_return = 1'b0;
        err_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        read_expect(PWR_CTRL_ADDR, 32'h0000_0010, 1'b0); // power-on value
        apb(1'b1, PWR_CTRL_ADDR, 32'h0000_00FC);
        read_expect(PWR_CTRL_ADDR, 32'h0000_00DC, 1'b0); // writable fields
        apb(1'b1, 12'h220, 32'h0000_00FF);
        read_expect(PWR_CTRL_ADDR, 32'h0000_00DC, 1'b0); // stray write ignored
        read_expect(12'h220, 32'h0000_0000, 1'b1); // unmapped refused
        @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        #1;
        check({31'h0, pready}, 32'h0, "pready while frozen"); // frozen block
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("test registers done");
        for (s = 0; s < 2; s++) begin
            apb(1'b1, PWR_CTRL_ADDR, 32'h0000_000E);
            @(posedge pclk);
            #1;
            check({31'h0, power_down_bit}, 32'h1, "power-down bit set"); // entry
            check({29'h0, core_ctl.osc_en, core_ctl.core_clk_en, core_ctl.periph_clk_en},
                  32'h0, "clocks stopped"); // all stopped
            fork
                partner_u.drive_wake(s, 260);
                begin
                    repeat (3) @(posedge pclk);
                    #1;
                    check({31'h0, power_down_bit}, 32'h0, "bit cleared"); // hw clear
                    check({31'h0, core_ctl.osc_en}, 32'h1, "osc on"); // restart
                    repeat (210) @(posedge pclk);
                    #1;
                    check({28'h0, core_ctl.core_clk_en, core_ctl.periph_clk_en,
                           core_ctl.exec_hold, isr_request}, 32'hE, "held"); // held
                end
            join
            wait_hi(0);
            check({30'h0, isr_source}, 32'h1 << s, "wake source"); // source
            check({31'h0, isr_request}, 32'h1, "service request"); // service
            @(posedge pclk);
            isr_return <= 1'b1;
            @(posedge pclk);
            isr_return <= 1'b0;
            wait_hi(1);
            check({31'h0, resume_next}, 32'h1, "resume next"); // resume
            read_expect(PWR_CTRL_ADDR, 32'h0000_000C, 1'b0); // fields kept
            $display("test wake source %0d done", s);
        end
        apb(1'b1, PWR_CTRL_ADDR, 32'h0000_000E);
        @(posedge pclk);
        fork
            partner_u.drive_reset(12);
            begin
                @(posedge pclk);
                #1;
                check({31'h0, power_down_bit}, 32'h0, "cleared at once"); // async
                @(posedge pclk);
                #1;
                check({30'h0, core_ctl.core_clk_en, core_ctl.ram_block},
                      32'h3, "brief run"); // ram blocked
            end
        join
        wait_hi(2);
        check({31'h0, sfr_init}, 32'h1, "register reload"); // reload
        check({16'h0, fetch_addr}, {16'h0, RESET_VECTOR}, "restart address"); // vector
        read_expect(PWR_CTRL_ADDR, {24'h0, PWR_CTRL_RESET}, 1'b0); // defaults back
        $display("test reset wake done");
        // reset pin while running goes straight to the reset sequence
        partner_u.drive_reset(3);
        wait_hi(2);
        check({31'h0, vector_load}, 32'h1, "restart from run"); // vector
        $display("test reset from run done");
        final_report();
    end
endmodule
